// File: dual_bus_pkg.sv
// Functional notes
// - Bus B word arrival raises received flag
// - Bus B sync bit keeps last sync
// - Bus B idle bit follows bus silence
// - Bus B bad Manchester word sets error
// - Transmit window opens 3.5 us after start
// - Transmit window closes 18.5 us after start
// - Word written in window goes back to back
// - Register select picks status or channel data
// - Data read drives sync pin with sync
// - Sync bits kept per bus independently
// - Receiver enable bits gate each receiver
// - Transmitted words are received on same channel
// - Bus A flag clears on read or start
// - Bus A idle bit follows bus silence
// - Bus A bad Manchester word sets error
// - Channel select is register bit OR pin
`default_nettype none
package dual_bus_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int TX_OPEN_NS    = 3500;
  localparam int TX_CLOSE_NS   = 18500;
  localparam int TX_WORD_NS    = 20000;

  localparam logic [10:0] TX_OPEN_CYCLES =
    11'((TX_OPEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [10:0] TX_CLOSE_CYCLES =
    11'(TX_CLOSE_NS / CLK_PERIOD_NS);
  localparam logic [10:0] TX_WORD_CYCLES =
    11'(TX_WORD_NS / CLK_PERIOD_NS);

  localparam int BIT_TX_DISABLE_A   = 0;
  localparam int BIT_TX_DISABLE_B   = 1;
  localparam int BIT_RX_ENABLE_A    = 2;
  localparam int BIT_TX_SYNC        = 4;
  localparam int BIT_CHANNEL_SELECT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h0c;

  localparam int TX_FIFO_DEPTH = 8;

  typedef struct packed {
    logic [15:0] data;
    logic        sync;
    logic        bus_b;
  } tx_word_s;

  typedef struct packed {
    logic        active;
    logic        word_start;
    logic        word_valid;
    logic        error;
    logic        sync;
    logic [15:0] data;
  } rx_word_s;

  typedef struct packed {
    logic        strobe_n;
    logic        read_write;
    logic        reg_select;
    logic        channel_select_bit_pin;
    logic        sync;
    logic [15:0] data;
  } host_pins_s;

endpackage
`default_nettype wire

// File: dual_bus_status_port.sv
`timescale 1ns/1ps
`default_nettype none
module dual_bus_status_port (
  input  wire logic                    ref_clk,
  input  wire logic                    reset_n,
  input  wire logic                    host_strobe_n,
  input  wire logic                    read_write,
  input  wire logic                    reg_select,
  input  wire logic                    channel_select_pin,
  input  wire logic [15:0]             data_in,
  output logic      [15:0]             data_out,
  output logic                         data_oe,
  input  wire logic                    sync_in,
  output logic                         sync_out,
  output logic                         sync_oe,
  output logic                         word_received_a,
  output logic                         word_received_b,
  input  wire dual_bus_pkg::rx_word_s  rx_word_a,
  input  wire dual_bus_pkg::rx_word_s  rx_word_b,
  output logic                         tx_start,
  output dual_bus_pkg::tx_word_s       tx_word,
  output logic                         tx_space,
  output logic                         tx_disable_a,
  output logic                         tx_disable_b
);
  import dual_bus_pkg::*;

  logic        rst_meta_reg;
  logic        rst_n;
  host_pins_s  pin_meta_reg;
  host_pins_s  pin_reg;
  host_pins_s  pin_raw;
  logic        strobe_d_reg;
  logic [5:0]  ctrl_reg;
  logic [1:0]  rcv_reg;
  logic [1:0]  sync_st_reg;
  logic [1:0]  idle_reg;
  logic [1:0]  err_reg;
  logic [15:0] rx_data_reg [2];
  logic [15:0] data_out_reg;
  logic        data_oe_reg;
  logic        sync_out_reg;
  logic        sync_oe_reg;
  logic        busy_reg;
  logic [10:0] count_reg;
  tx_word_s    cur_reg;
  logic        window_reg;
  logic        tx_start_reg;
  tx_word_s    tx_word_reg;
  logic        tx_space_reg;

  rx_word_s    rxw [2];
  logic        fall;
  logic        rd_fire;
  logic        wr_fire;
  logic        channel_select_bit_eff;
  logic [15:0] status;
  logic [15:0] rd_data;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  tx_word_s    fifo_out;
  tx_word_s    fifo_in;
  logic        tx_last;
  logic        pop;
  logic        start_go;
  logic        tx_end;
  logic        busy_next;
  logic [10:0] count_next;
  logic        window_next;
  logic [1:0]  got;
  logic [1:0]  start;
  logic [1:0]  rd_clr;
  logic [1:0]  bad;

  assign rxw[0] = rx_word_a;
  assign rxw[1] = rx_word_b;
  assign pin_raw = '{strobe_n: host_strobe_n, read_write: read_write,
                     reg_select: reg_select, channel_select_bit_pin: channel_select_pin,
                     sync: sync_in, data: data_in};

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Host pins are asynchronous; only the second stage is used.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= '{strobe_n: 1'b1, default: '0};
      pin_reg      <= '{strobe_n: 1'b1, default: '0};
      strobe_d_reg <= 1'b1;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_reg      <= pin_meta_reg;
      strobe_d_reg <= pin_reg.strobe_n;
    end
  end

  assign fall     = strobe_d_reg && !pin_reg.strobe_n;
  assign rd_fire  = fall && pin_reg.read_write;
  assign wr_fire  = fall && !pin_reg.read_write;
  assign channel_select_bit_eff = ctrl_reg[BIT_CHANNEL_SELECT] | pin_reg.channel_select_bit_pin;
  assign status   = {window_reg, err_reg[1], idle_reg[1], sync_st_reg[1],
                     rcv_reg[1], err_reg[0], idle_reg[0], sync_st_reg[0],
                     rcv_reg[0], 1'b0, ctrl_reg};
  assign rd_data  = pin_reg.reg_select ? status
                    : rx_data_reg[channel_select_bit_eff];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_fire && pin_reg.reg_select) begin
      ctrl_reg <= pin_reg.data[5:0];
    end
  end

  // Drivers stay on until the strobe returns high.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out_reg <= 16'h0000;
      data_oe_reg  <= 1'b0;
      sync_out_reg <= 1'b0;
      sync_oe_reg  <= 1'b0;
    end else if (rd_fire) begin
      data_out_reg <= rd_data;
      data_oe_reg  <= 1'b1;
      sync_out_reg <= sync_st_reg[channel_select_bit_eff];
      sync_oe_reg  <= !pin_reg.reg_select;
    end else if (pin_reg.strobe_n) begin
      data_oe_reg <= 1'b0;
      sync_oe_reg <= 1'b0;
    end
  end

  assign fifo_in = '{data: pin_reg.data, bus_b: channel_select_bit_eff,
                     sync: pin_reg.sync | ctrl_reg[BIT_TX_SYNC]};

  // A write that finds the buffer full is dropped; tx_space warns.
  word_fifo #(
    .WIDTH ($bits(tx_word_s)),
    .DEPTH (TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (wr_fire && !pin_reg.reg_select),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out)
  );

  assign tx_last     = count_reg == TX_WORD_CYCLES - 11'd1;
  assign tx_end      = busy_reg && tx_last;
  assign pop         = !busy_reg || tx_last;
  assign start_go    = fifo_out_valid && pop;
  assign busy_next   = start_go || (busy_reg && !tx_last);
  assign count_next  = start_go ? 11'd0
                       : (busy_reg ? count_reg + 11'd1 : count_reg);
  assign window_next = !busy_next
                       || (count_next >= TX_OPEN_CYCLES
                           && count_next < TX_CLOSE_CYCLES);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg     <= 1'b0;
      count_reg    <= 11'd0;
      cur_reg      <= '0;
      window_reg   <= 1'b1;
      tx_start_reg <= 1'b0;
      tx_word_reg  <= '0;
      tx_space_reg <= 1'b1;
    end else begin
      busy_reg     <= busy_next;
      count_reg    <= count_next;
      window_reg   <= window_next;
      tx_start_reg <= start_go;
      tx_space_reg <= fifo_in_ready;
      if (start_go) begin
        cur_reg     <= fifo_out;
        tx_word_reg <= fifo_out;
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_bus
      logic en;
      logic mine;
      assign en   = ctrl_reg[BIT_RX_ENABLE_A + ch];
      assign mine = cur_reg.bus_b == 1'(ch);
      assign got[ch]    = (tx_end && mine)
                          || (en && rxw[ch].word_valid && !rxw[ch].error);
      assign start[ch]  = (start_go && fifo_out.bus_b == 1'(ch))
                          || (en && rxw[ch].word_start);
      assign rd_clr[ch] = rd_fire && !pin_reg.reg_select
                          && channel_select_bit_eff == 1'(ch);
      assign bad[ch]    = en && rxw[ch].word_valid && rxw[ch].error;

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          rcv_reg[ch]     <= 1'b0;
          sync_st_reg[ch] <= 1'b0;
          idle_reg[ch]    <= 1'b0;
          err_reg[ch]     <= 1'b0;
          rx_data_reg[ch] <= 16'h0000;
        end else begin
          // A new word wins over a clear in the same cycle.
          rcv_reg[ch]  <= got[ch] || (rcv_reg[ch]
                          && !(start[ch] || rd_clr[ch]));
          err_reg[ch]  <= bad[ch] || (err_reg[ch] && !start[ch]);
          idle_reg[ch] <= !((en && rxw[ch].active)
                          || (busy_reg && mine));
          if (got[ch]) begin
            sync_st_reg[ch] <= tx_end && mine ? cur_reg.sync
                               : rxw[ch].sync;
            rx_data_reg[ch] <= tx_end && mine ? cur_reg.data
                               : rxw[ch].data;
          end
        end
      end
    end
  endgenerate

  assign data_out        = data_out_reg;
  assign data_oe         = data_oe_reg;
  assign sync_out        = sync_out_reg;
  assign sync_oe         = sync_oe_reg;
  assign word_received_a = rcv_reg[0];
  assign word_received_b = rcv_reg[1];
  assign tx_start        = tx_start_reg;
  assign tx_word         = tx_word_reg;
  assign tx_space        = tx_space_reg;
  assign tx_disable_a    = ctrl_reg[BIT_TX_DISABLE_A];
  assign tx_disable_b    = ctrl_reg[BIT_TX_DISABLE_B];

  AST_WORD_RECEIVED_B_SET: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    got[1] |=> word_received_b && status[11])
    else $error("bus B flag did not rise on a word");

  AST_SYNCB_KEPT: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (ctrl_reg[3] && rx_word_b.word_valid && !rx_word_b.error && !tx_end)
    |=> status[12] == $past(rx_word_b.sync))
    else $error("bus B sync bit does not hold last sync");

  AST_IDLEB: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (ctrl_reg[3] && rx_word_b.active) |=> !status[13])
    else $error("bus B idle bit high during traffic");

  AST_ERRB: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    bad[1] |=> status[14])
    else $error("bus B decode error not flagged");

  logic [11:0] start_age_reg;

  // Counts cycles since the last word start, apart from the word timer.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_age_reg <= 12'h000;
    end else if (tx_start_reg) begin
      start_age_reg <= 12'h001;
    end else if (start_age_reg != 12'h000 && start_age_reg != 12'hfff) begin
      start_age_reg <= start_age_reg + 12'h001;
    end
  end

  AST_WIN_OPEN: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (busy_reg && start_age_reg == {1'b0, TX_OPEN_CYCLES})
    |-> window_reg && !$past(window_reg))
    else $error("transmit window opened at wrong time");

  AST_WIN_CLOSE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (busy_reg && count_reg == TX_CLOSE_CYCLES)
    |-> !window_reg && $past(window_reg))
    else $error("transmit window closed at wrong time");

  AST_BACK_TO_BACK: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (tx_end && fifo_out_valid)
    |=> busy_reg && count_reg == 11'd0 && tx_start)
    else $error("queued word not sent back to back");

  AST_READ_STATUS: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (rd_fire && pin_reg.reg_select)
    |=> data_oe && data_out == $past(status) && !sync_oe)
    else $error("status read returned wrong data");

  AST_READ_SYNC_A: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (rd_fire && !pin_reg.reg_select && !channel_select_bit_eff)
    |=> sync_oe && sync_out == $past(sync_st_reg[0])
        && data_out == $past(rx_data_reg[0]))
    else $error("receiver A read gave wrong sync or data");

  AST_RX_GATED_A: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (!ctrl_reg[2] && !(tx_end && !cur_reg.bus_b)) |=> $stable(rx_data_reg[0]))
    else $error("disabled receiver A stored a word");

  AST_SELF_RX: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (tx_end && cur_reg.bus_b) |=> word_received_b
      && rx_data_reg[1] == $past(cur_reg.data))
    else $error("own transmitted word not received");

  AST_WORD_RECEIVED_A_CLR: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (rd_clr[0] && !got[0]) |=> !word_received_a)
    else $error("bus A flag not cleared by a read");

  AST_CHANNEL_SELECT_BIT_OR: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_fire && !pin_reg.reg_select && fifo_in_ready)
    |-> fifo_in.bus_b == (ctrl_reg[5] || pin_reg.channel_select_bit_pin))
    else $error("channel select is not bit OR pin");
endmodule
`default_nettype wire

// File: host_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe,
  input  wire logic        sync_out,
  input  wire logic        sync_oe,
  output logic             host_strobe_n,
  output logic             read_write,
  output logic             reg_select,
  output logic             channel_select_pin,
  output logic      [15:0] data_in,
  output logic             sync_in
);
  initial begin
    host_strobe_n = 1'b1;
    read_write = 1'b1;
    reg_select = 1'b0;
    channel_select_pin = 1'b0;
    data_in = 16'h0000;
    sync_in = 1'b0;
  end

  // Lines the host releases show the inverse of their last value.
  task automatic access(input logic rw, input logic rs, input logic ch,
                        input logic [15:0] d, input logic s,
                        output logic [15:0] q, output logic qs);
    @(negedge ref_clk);
    read_write = rw;
    reg_select = rs;
    channel_select_pin = ch;
    data_in = rw ? ~data_in : d;
    sync_in = rw ? ~sync_in : s;
    host_strobe_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    q = (data_oe === 1'b1) ? data_out : 16'hxxxx;
    qs = (sync_oe === 1'b1) ? sync_out : 1'bx;
    host_strobe_n = 1'b1;
    data_in = ~data_in;
    sync_in = ~sync_in;
    repeat (6) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dual_bus_pkg::*;
  logic        ref_clk;
  logic        reset_n;
  logic        strobe_n;
  logic        rw;
  logic        rsel;
  logic        chp;
  logic        sync_in;
  logic        sync_out;
  logic        sync_oe;
  logic        data_oe;
  logic        rcv_a;
  logic        rcv_b;
  logic        tx_start;
  logic        tx_space;
  logic        txd_a;
  logic        txd_b;
  logic [15:0] data_in;
  logic [15:0] data_out;
  logic [15:0] q;
  logic        qs;
  logic [15:0] d;
  tx_word_s    tx_word;
  rx_word_s    rx [2];
  logic [3:0]  f [2];
  logic [15:0] rd [2];
  logic [5:0]  ctrl;
  logic [31:0] seed = 32'h0000_a10c;
  int          tcnt = 100000;
  int          gap;
  int          nst = 0;
  int          base;
  int          fail_count = 0;
  int          compares = 0;

  dual_bus_status_port uut (
    .ref_clk            (ref_clk),
    .reset_n            (reset_n),
    .host_strobe_n      (strobe_n),
    .read_write         (rw),
    .reg_select         (rsel),
    .channel_select_pin (chp),
    .data_in            (data_in),
    .data_out           (data_out),
    .data_oe            (data_oe),
    .sync_in            (sync_in),
    .sync_out           (sync_out),
    .sync_oe            (sync_oe),
    .word_received_a    (rcv_a),
    .word_received_b    (rcv_b),
    .rx_word_a          (rx[0]),
    .rx_word_b          (rx[1]),
    .tx_start           (tx_start),
    .tx_word            (tx_word),
    .tx_space           (tx_space),
    .tx_disable_a       (txd_a),
    .tx_disable_b       (txd_b)
  );

  host_port_model host (
    .ref_clk            (ref_clk),
    .data_out           (data_out),
    .data_oe            (data_oe),
    .sync_out           (sync_out),
    .sync_oe            (sync_oe),
    .host_strobe_n      (strobe_n),
    .read_write         (rw),
    .reg_select         (rsel),
    .channel_select_pin (chp),
    .data_in            (data_in),
    .sync_in            (sync_in)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Measures the spacing between word starts.
  always @(posedge ref_clk) begin
    if (tx_start === 1'b1) begin
      gap <= tcnt + 1;
      tcnt <= 0;
      nst <= nst + 1;
    end else begin
      tcnt <= tcnt + 1;
    end
  end

  function logic [15:0] rnd16();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  function automatic logic [15:0] st();
    return {1'b1, f[1], f[0], 1'b0, ctrl};
  endfunction

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chkb(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t bit got %b expected %b", $time, g, e);
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic rdr(input logic rs, input logic ch);
    host.access(1'b1, rs, ch, 16'h0000, 1'b0, q, qs);
  endtask

  task automatic wr(input logic rs, input logic ch, input logic [15:0] v,
                    input logic s);
    host.access(1'b0, rs, ch, v, s, q, qs);
  endtask

  task automatic ctl(input logic [5:0] c);
    ctrl = c;
    wr(1'b1, 1'b0, {10'h000, c}, 1'b0);
  endtask

  task automatic timeout();
    fail_count++;
    $display("ERROR t=%0t wait limit reached", $time);
    results();
  endtask

  task automatic wait_to(input int t);
    for (int k = 0; k < 4000 && tcnt < t; k++) @(negedge ref_clk);
    if (tcnt < t) timeout();
  endtask

  task automatic wait_nst(input int n, input int lim);
    for (int k = 0; k < lim && nst < n; k++) @(negedge ref_clk);
    if (nst < n) timeout();
  endtask

  // One receiver word: start pulse, then a finish pulse unless v is low.
  task automatic rxw(input int b, input logic v, input logic e);
    logic [15:0] w;
    w = rnd16();
    @(negedge ref_clk);
    rx[b].active = 1'b1;
    rx[b].word_start = 1'b1;
    @(negedge ref_clk);
    rx[b].word_start = 1'b0;
    repeat (3) @(negedge ref_clk);
    rx[b].word_valid = v;
    rx[b].error = e;
    rx[b].sync = w[0];
    rx[b].data = w;
    @(negedge ref_clk);
    rx[b] = '0;
    rx[b].data = ~w;
    if (ctrl[2+b]) begin
      f[b][0] = v & ~e;
      f[b][3] = v & e;
      if (v & ~e) begin
        f[b][1] = w[0];
        rd[b] = w;
      end
    end
  endtask

  task automatic results();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    rx[0] = '0;
    rx[1] = '0;
    f[0] = 4'h4;
    f[1] = 4'h4;
    ctrl = 6'h0c;
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    rdr(1'b1, 1'b0);
    chk(q, st());
    done("reset");
    for (int i = 0; i < 6; i++) begin
      rxw(i % 2, 1'b1, 1'b0);
      chkb((i % 2) ? rcv_b : rcv_a, 1'b1);
      rdr(1'b1, 1'b0);
      chk(q, st());
      rdr(1'b0, 1'(i % 2));
      chk(q, rd[i % 2]);
      chkb(qs, f[i % 2][1]);
      f[i % 2][0] = 1'b0;
      rdr(1'b1, 1'b0);
      chk(q, st());
    end
    done("receive");
    for (int b = 0; b < 2; b++) begin
      rxw(b, 1'b1, 1'b0);
      rxw(b, 1'b0, 1'b0);
      chkb(b ? rcv_b : rcv_a, 1'b0);
      rxw(b, 1'b1, 1'b1);
      rdr(1'b1, 1'b0);
      chk(q & ~16'h1100, st() & ~16'h1100);
      rx[b].active = 1'b1;
      rdr(1'b1, 1'b0);
      chkb(q[9+4*b], 1'b0);
      rx[b].active = 1'b0;
      rxw(b, 1'b1, 1'b0);
    end
    done("error_idle");
    rdr(1'b0, 1'b1);
    f[1][0] = 1'b0;
    ctl(6'h04);
    rxw(1, 1'b1, 1'b0);
    rdr(1'b1, 1'b0);
    chk(q, st());
    ctl(6'h0c);
    rxw(1, 1'b1, 1'b0);
    chkb(rcv_b, 1'b1);
    ctl(6'h2c);
    rdr(1'b0, 1'b0);
    chk(q, rd[1]);
    ctl(6'h0f);
    chkb(txd_a & txd_b, 1'b1);
    ctl(6'h0c);
    chkb(txd_a | txd_b, 1'b0);
    done("enable_select");
    d = rnd16();
    wr(1'b0, 1'b1, d, 1'b1);
    wait_nst(1, 20);
    chk(tx_word.data, d);
    chkb(tx_word.bus_b & tx_word.sync, 1'b1);
    wait_to(300);
    rdr(1'b1, 1'b0);
    chkb(q[15], 1'b0);
    wait_to(400);
    rdr(1'b1, 1'b0);
    chkb(q[15], 1'b1);
    d = rnd16();
    wr(1'b0, 1'b1, d, 1'b0);
    wait_to(1800);
    rdr(1'b1, 1'b0);
    chkb(q[15], 1'b1);
    wait_to(1900);
    rdr(1'b1, 1'b0);
    chkb(q[15], 1'b0);
    wait_nst(2, 400);
    chk(16'(gap), 16'h07d0);
    wait_to(2010);
    chkb(rcv_b, 1'b1);
    rdr(1'b0, 1'b1);
    chk(q, d);
    chkb(qs, 1'b0);
    done("transmit");
    base = nst;
    for (int k = 0; k < 10; k++) begin
      if (k == 9) chkb(tx_space, 1'b0);
      wr(1'b0, 1'b0, rnd16(), 1'b0);
    end
    wait_nst(base + 9, 20000);
    wait_to(2100);
    chk(16'(nst - base), 16'h0009);
    chkb(tx_space, 1'b1);
    done("buffer");
    results();
  end
endmodule
`default_nettype wire

// File: word_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign in_ready  = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0])
                     || (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire
